/* File: hw/sts_buf2.sv */
// two-entry buffer of forwarding results
`timescale 1ns/10ps
module sts_buf2 (
  // clock and reset
  input wire logic   core_clk,
  input wire logic   reset_n,
  // buffered path
  sts_buf_if.buffer  bif
);
  sts_pkg::sts_result_type mem_q [2];
  logic                    wr_ptr_q;
  logic                    rd_ptr_q;
  logic [1:0]              count_q;
  logic                    push;
  logic                    pop;

  assign bif.push_ready = (count_q != 2'h2);
  assign bif.pop_valid  = (count_q != 2'h0);
  assign bif.pop_data   = mem_q[rd_ptr_q];
  assign push           = bif.push_valid && bif.push_ready;
  assign pop            = bif.pop_valid && bif.pop_ready;

  // ----------------------------------------
  // storage
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      mem_q[0] <= '0;
      mem_q[1] <= '0;
    end else if (push) begin
      mem_q[wr_ptr_q] <= bif.push_data;
    end
  end

  // ----------------------------------------
  // pointers and fill level
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_ptr_q <= 1'b0;
      rd_ptr_q <= 1'b0;
      count_q  <= 2'h0;
    end else begin
      if (push) begin
        wr_ptr_q <= ~wr_ptr_q;
      end
      if (pop) begin
        rd_ptr_q <= ~rd_ptr_q;
      end
      if (push && !pop) begin
        count_q <= count_q + 2'h1;
      end else if (pop && !push) begin
        count_q <= count_q - 2'h1;
      end
    end
  end
endmodule : sts_buf2

/* File: hw/sts_port_state.sv */
// spanning tree state gating of forwarding and learning decisions
`timescale 1ns/10ps
`include "sts_cfg.svh"
module sts_port_state (
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       reset_n,
  // register access
  input  wire logic [7:0] reg_addr,
  input  wire logic       reg_wr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  // lookup result in
  input  wire logic       dec_valid,
  output logic            dec_ready,
  input  wire logic [1:0] dec_src_port,
  input  wire logic [2:0] dec_lookup_mask,
  input  wire logic       dec_override,
  input  wire logic [1:0] dec_tag_mask,
  // gated result out
  output logic            res_valid,
  input  wire logic       res_ready,
  output logic      [2:0] res_fwd_mask,
  output logic            res_learn
);
  logic [7:0]              p1_ctl_q;
  logic [7:0]              p2_ctl_q;
  logic [7:0]              reg_rdata_q;
  sts_pkg::sts_result_type dec_d;
  sts_buf_if               bif ();

  // ----------------------------------------
  // control registers
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      p1_ctl_q <= `STS_CTL_RESET;
      p2_ctl_q <= `STS_CTL_RESET;
    end else if (reg_wr) begin
      if (reg_addr == `STS_P1_CTL_ADDR) begin
        p1_ctl_q <= reg_wdata; // R2
      end
      if (reg_addr == `STS_P2_CTL_ADDR) begin
        p2_ctl_q <= reg_wdata; // R2
      end
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata_q <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        `STS_P1_CTL_ADDR: reg_rdata_q <= p1_ctl_q; // R2
        `STS_P2_CTL_ADDR: reg_rdata_q <= p2_ctl_q; // R2
        default:          reg_rdata_q <= 8'h00;
      endcase
    end
  end
  assign reg_rdata = reg_rdata_q;

  // ----------------------------------------
  // decision
  // ----------------------------------------
  function automatic sts_pkg::sts_result_type decide(
    input logic [1:0] src,
    input logic [2:0] lookup,
    input logic       ovr,
    input logic [1:0] tag,
    input logic [7:0] c1,
    input logic [7:0] c2
  );
    sts_pkg::sts_result_type r;
    logic [7:0]              own;
    r.fwd_mask = lookup;
    r.learn    = 1'b0;
    own        = (src == `STS_PORT1) ? c1 : c2;
    if (src == `STS_PORT3 && tag != 2'h0) begin
      r.fwd_mask = {1'b0, tag}; // R14
      r.learn    = 1'b1;
    end else if (src == `STS_PORT3) begin
      r.learn = 1'b1; // R1
      r.fwd_mask[2] = 1'b0;
      r.fwd_mask[0] = lookup[0] & c1[`STS_TX_EN_BIT]; // R3 R5 R6
      r.fwd_mask[1] = lookup[1] & c2[`STS_TX_EN_BIT]; // R3 R5 R6
    end else if (src == `STS_PORT1 || src == `STS_PORT2) begin
      r.learn = ~own[`STS_LRN_DIS_BIT]; // R7 R8 R9
      if (ovr) begin
        r.fwd_mask = `STS_MASK_CPU; // R4 R10
      end else if (!own[`STS_RX_EN_BIT]) begin
        r.fwd_mask = lookup & `STS_MASK_CPU; // R3 R5 R6
      end else begin
        r.fwd_mask[0] = lookup[0] & c1[`STS_TX_EN_BIT] & (src != `STS_PORT1); // R8
        r.fwd_mask[1] = lookup[1] & c2[`STS_TX_EN_BIT] & (src != `STS_PORT2); // R8
      end
    end else begin
      r.fwd_mask = 3'h0;
    end
    return r;
  endfunction : decide

  assign dec_d = decide(dec_src_port, dec_lookup_mask, dec_override, dec_tag_mask,
                        p1_ctl_q, p2_ctl_q);

  // ----------------------------------------
  // result buffer
  // ----------------------------------------
  assign bif.push_valid = dec_valid;
  assign bif.push_data  = dec_d;
  assign dec_ready      = bif.push_ready;
  assign bif.pop_ready  = res_ready;
  assign res_valid      = bif.pop_valid;
  assign res_fwd_mask   = bif.pop_data.fwd_mask;
  assign res_learn      = bif.pop_data.learn;

  sts_buf2 u_buf (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .bif      (bif)
  );

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  logic push_net;
  logic [7:0] src_ctl;
  assign push_net = dec_valid && dec_ready &&
                    (dec_src_port == `STS_PORT1 || dec_src_port == `STS_PORT2);
  assign src_ctl  = (dec_src_port == `STS_PORT1) ? p1_ctl_q : p2_ctl_q;

  reg_read_back_a: assert property ( // R2
    reg_rd && reg_addr == `STS_P1_CTL_ADDR |=> reg_rdata == $past(p1_ctl_q))
    else $error("port 1 control read back wrong");
  reg_write_a: assert property ( // R2
    reg_wr && reg_addr == `STS_P2_CTL_ADDR |=> p2_ctl_q == $past(reg_wdata))
    else $error("port 2 control write lost");
  unmapped_zero_a: assert property (
    reg_rd && reg_addr != `STS_P1_CTL_ADDR && reg_addr != `STS_P2_CTL_ADDR
    |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  rx_gate_a: assert property ( // R5
    push_net && !src_ctl[`STS_RX_EN_BIT] && !dec_override
    |-> (dec_d.fwd_mask & `STS_MASK_NET) == 3'h0)
    else $error("blocked receive reached network port");
  override_cpu_a: assert property ( // R10
    push_net && dec_override |-> dec_d.fwd_mask == `STS_MASK_CPU)
    else $error("override frame not sent to processor");
  learn_off_a: assert property ( // R9
    push_net && src_ctl[`STS_LRN_DIS_BIT] |-> !dec_d.learn)
    else $error("learned with learning disabled");
  learn_on_a: assert property ( // R7
    push_net && !src_ctl[`STS_LRN_DIS_BIT] |-> dec_d.learn)
    else $error("no learning with learning enabled");
  tx_gate_a: assert property ( // R3
    dec_valid && dec_ready && !p1_ctl_q[`STS_TX_EN_BIT] &&
    !(dec_src_port == `STS_PORT3 && dec_tag_mask != 2'h0) |-> !dec_d.fwd_mask[0])
    else $error("frame sent to transmit-disabled port");
  tag_bypass_a: assert property ( // R14
    dec_valid && dec_ready && dec_src_port == `STS_PORT3 && dec_tag_mask != 2'h0
    |-> dec_d.fwd_mask == {1'b0, dec_tag_mask})
    else $error("tag mask not honoured");
  result_arrives_a: assert property (
    dec_valid && dec_ready && !res_valid |=> res_valid ##0
    res_fwd_mask == $past(dec_d.fwd_mask))
    else $error("result not presented next cycle");

  stall_full_c: cover property (res_valid && !res_ready ##1 !dec_ready);
  override_c:   cover property (push_net && dec_override && !src_ctl[`STS_RX_EN_BIT]);
  bypass_c:     cover property (dec_valid && dec_ready && dec_tag_mask == 2'h3);
endmodule : sts_port_state

/* File: shared/sts_buf_if.sv */
// carrier between the decision logic and its two-entry buffer
`timescale 1ns/10ps
interface sts_buf_if;
  logic                   push_valid;
  logic                   push_ready;
  sts_pkg::sts_result_type push_data;
  logic                   pop_valid;
  logic                   pop_ready;
  sts_pkg::sts_result_type pop_data;
  modport buffer (input push_valid, output push_ready, input push_data,
                  output pop_valid, input pop_ready, output pop_data);
  modport user   (output push_valid, input push_ready, output push_data,
                  input pop_valid, output pop_ready, input pop_data);
endinterface : sts_buf_if

/* File: shared/sts_cfg.svh */
// constants of the spanning tree port state block
// Summary of operation
// R1 - port 3 is processor port, never state-gated
// R2 - control bits live at 0x12 and 0x22
// R3 - disabled port neither forwards nor accepts frames; code still passes its processor-bound and override frames to port 3
// R4 - override static hits still reach processor
// R5 - blocking port sends only processor-bound frames
// R6 - listening/learning pass processor traffic only
// R7 - learning state learns source addresses
// R8 - forwarding state passes traffic and learns
// R9 - learning disable stops address learning
// R10 - override static hits go to processor always
// R11 - processor sends nothing to blocked ports
// R12 - processor drops override frames from disabled
// R13 - processor programs override entries beforehand
// R14 - nonzero tag mask bypasses lookup and state
`ifndef STS_CFG_SVH
`define STS_CFG_SVH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define STS_P1_CTL_ADDR 8'h12
`define STS_P2_CTL_ADDR 8'h22
// ----------------------------------------
// control field positions and reset
// ----------------------------------------
`define STS_TX_EN_BIT    2
`define STS_RX_EN_BIT    1
`define STS_LRN_DIS_BIT  0
`define STS_CTL_RESET    8'h06
// ----------------------------------------
// port codes and mask positions
// ----------------------------------------
`define STS_PORT1        2'h1
`define STS_PORT2        2'h2
`define STS_PORT3        2'h3
`define STS_MASK_CPU     3'h4
`define STS_MASK_NET     3'h3
`endif

/* File: shared/sts_pkg.sv */
// types of the spanning tree port state block
package sts_pkg;
  typedef struct packed {
    logic [2:0] fwd_mask;
    logic       learn;
  } sts_result_type;
endpackage : sts_pkg

/* File: verification/sts_port_state_tb_top.sv */
// self-checking bench of the port state gating
`timescale 1ns/10ps
module sts_port_state_tb_top;
  logic       core_clk, reset_n, reg_wr, reg_rd, dec_valid, dec_override, stall_en;
  logic       dec_ready, res_valid, res_ready, res_learn;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, ctl1, ctl2;
  logic [1:0] dec_src_port, dec_tag_mask;
  logic [2:0] dec_lookup_mask, res_fwd_mask;
  logic [3:0] exp_q[$];
  logic [7:0] st[5] = '{8'h01, 8'h00, 8'h06, 8'h02, 8'h04};
  int         fail_count, check_count, n, g;
  sts_port_state dut_u (.core_clk(core_clk), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .dec_valid(dec_valid), .dec_ready(dec_ready), .dec_src_port(dec_src_port),
    .dec_lookup_mask(dec_lookup_mask), .dec_override(dec_override),
    .dec_tag_mask(dec_tag_mask), .res_valid(res_valid), .res_ready(res_ready),
    .res_fwd_mask(res_fwd_mask), .res_learn(res_learn));
  sts_sink_model sink_u (.core_clk(core_clk), .reset_n(reset_n), .stall_en(stall_en),
    .res_valid(res_valid), .res_ready(res_ready));
  function automatic logic [3:0] exp_of(logic [1:0] s, logic [2:0] lk, logic o, logic [1:0] t);
    logic [7:0] c;
    logic [2:0] m;
    c = (s == 2'h1) ? ctl1 : ctl2;
    if (s == 2'h0) return 4'h0;
    if (s == 2'h3) begin
      m = (t != 2'h0) ? {1'b0, t} : {1'b0, lk[1] & ctl2[2], lk[0] & ctl1[2]};
      return {m, 1'b1};
    end
    if (o) m = 3'h4;
    else if (!c[1]) m = lk & 3'h4;
    else m = {lk[2], lk[1] & ctl2[2] & (s != 2'h2), lk[0] & ctl1[2] & (s != 2'h1)};
    return {m, !c[0]};
  endfunction : exp_of
  task automatic check(logic [7:0] got, logic [7:0] want, string what);
    check_count++;
    if (got !== want) begin
      fail_count++;
      $display("[FAIL] %0t %s got %h want %h", $time, what, got, want);
    end
  endtask : check
  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : close_out
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(logic [7:0] a, logic [7:0] want);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 check(reg_rdata, want, "register read");
  endtask : rd
  always @(posedge core_clk) begin
    if (reset_n && res_valid && res_ready)
      check({4'h0, res_fwd_mask, res_learn}, {4'h0, exp_q.pop_front()}, "result");
    if (reset_n && dec_valid && dec_ready)
      exp_q.push_back(exp_of(dec_src_port, dec_lookup_mask, dec_override, dec_tag_mask));
  end
  task automatic burst(int cnt);
    n = 0;
    for (g = 0; g < cnt * 20 && n < cnt; g++) begin
      @(posedge core_clk);
      if (dec_valid && dec_ready) n++;
      if (n == cnt) dec_valid <= 1'b0;
      else if (!dec_valid || dec_ready) begin
        dec_valid       <= ($urandom % 4) != 0;
        dec_src_port    <= 2'($urandom);
        dec_lookup_mask <= 3'($urandom);
        dec_override    <= ($urandom % 4) == 0;
        dec_tag_mask    <= (($urandom % 2) ? 2'($urandom) : 2'h0) &
                           {ctl2[2] | !ctl2[0], ctl1[2] | !ctl1[0]};
      end
    end
    for (g = 0; g < 200 && (exp_q.size() != 0 || dec_valid); g++) @(posedge core_clk);
    if (g == 200) begin
      fail_count++;
      $display("[FAIL] %0t stream did not drain", $time);
      close_out();
    end
  endtask : burst
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  initial begin
    {reset_n, reg_wr, reg_rd, dec_valid, dec_override, stall_en} = '0;
    {reg_addr, reg_wdata, dec_src_port, dec_tag_mask, dec_lookup_mask} = '0;
    n = $urandom(71041);
    repeat (2) @(posedge core_clk);
    reset_n <= 1'b1;
    rd(8'h12, 8'h06);
    rd(8'h22, 8'h06);
    rd(8'h40, 8'h00);
    wr(8'h40, 8'hff);
    rd(8'h12, 8'h06);
    rd(8'h22, 8'h06);
    for (int i = 0; i < 7; i++) begin
      ctl1 = (i < 5) ? st[i] : 8'($urandom);
      ctl2 = (i < 5) ? st[(i + 2) % 5] : 8'($urandom);
      stall_en <= i[0];
      wr(8'h12, ctl1);
      wr(8'h22, ctl2);
      rd(8'h12, ctl1);
      rd(8'h22, ctl2);
      burst(60);
      $display("test %0d done", i);
    end
    close_out();
  end
endmodule : sts_port_state_tb_top

/* File: verification/sts_sink_model.sv */
// far-side consumer of gated results
`timescale 1ns/10ps
module sts_sink_model (
  // clock and reset
  input  wire logic core_clk,
  input  wire logic reset_n,
  // result stream
  input  wire logic stall_en,
  input  wire logic res_valid,
  output logic      res_ready
);
  logic [7:0] lfsr_q;
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) lfsr_q <= 8'h5a;
    else lfsr_q <= {lfsr_q[6:0], lfsr_q[7] ^ lfsr_q[5] ^ lfsr_q[4] ^ lfsr_q[3]};
  end
  // stalls at random when stall_en is set, else takes every frame it sees
  assign res_ready = !stall_en || lfsr_q[0] || !res_valid;
endmodule : sts_sink_model
